// ---- hws_sequencer.sv ----
// waveform hop sequencer: sixteen-step table, step timing, marker pulse, run/stop, exit restore, power-down save
// assumes all inputs are synchronous to core_clk; key and command inputs other than escape_key are one-cycle pulses
//
// Operation
// - sixteen steps, each preset to default set-up
// - run from step 00 to last, then wrap
// - each step has own mode and duration
// - internal duration 2 ms to 65 s, 1 ms
// - duration 1 means external, 0 manual
// - external mode: one step per rising edge
// - manual mode: one step per key or command
// - marker low at entry, high once applied
// - external: marker falls about 1 ms later
// - marker rise 0.5 ms freq, 3 ms shape
// - amplitude/offset marker rise at 10 ms
// - attenuator change: output off 45 ms first
// - duration timed from marker rising edge
// - frequency-only change keeps phase continuous
// - run/stop toggles; editing blocked while running
// - exit stops and restores previous setting
// - display only manual or over 500 ms steps
// - escape held one second forces exit
// - table saved at power-down, survives defaults
`timescale 1ns/1ps
`default_nettype none

module hws_sequencer #(
  parameter int unsigned HALF_MS_CYC = hws_pkg::HALF_MS_CYC
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // front panel and remote control
  input  wire logic                        hop_enter,
  input  wire logic                        hop_exit,
  input  wire logic                        escape_key,
  input  wire logic                        run_toggle,
  input  wire logic                        manual_step_key,
  input  wire logic                        remote_step,
  input  wire logic                        external_step_input,
  // step editing and restore from non-volatile memory
  input  wire logic                        edit_we,
  input  wire logic [hws_pkg::IDX_W-1:0]   edit_idx,
  input  wire logic [hws_pkg::SETUP_W-1:0] edit_setup,
  input  wire logic [hws_pkg::DUR_W-1:0]   edit_dur,
  input  wire logic                        last_we,
  input  wire logic [hws_pkg::IDX_W-1:0]   last_data,
  // generator setting in force before hop
  input  wire logic [hws_pkg::SETUP_W-1:0] main_setup,
  // power-down save request
  input  wire logic                        pwr_down,
  // towards synthesis and output stages
  output var  logic [hws_pkg::SETUP_W-1:0] wave_setup,
  output var  logic                        wave_load,
  output var  logic                        phase_keep,
  output var  logic                        output_enable,
  output var  logic                        step_marker_output,
  // status
  output var  logic                        hop_active,
  output var  logic                        hop_running,
  output var  logic [hws_pkg::IDX_W-1:0]   step_idx,
  output var  logic                        disp_update,
  output var  logic [hws_pkg::IDX_W-1:0]   disp_idx,
  output var  logic                        edit_blocked,
  // non-volatile save stream
  output var  logic                        nv_valid,
  output var  logic [hws_pkg::IDX_W-1:0]   nv_idx,
  output var  logic [hws_pkg::SETUP_W-1:0] nv_setup,
  output var  logic [hws_pkg::DUR_W-1:0]   nv_dur,
  output var  logic [hws_pkg::IDX_W-1:0]   nv_last
);
  localparam int unsigned SW = hws_pkg::SETUP_W;
  localparam int unsigned IW = hws_pkg::IDX_W;
  localparam int unsigned DW = hws_pkg::DUR_W;
  localparam int unsigned CW = hws_pkg::CNT_W;

  if (HALF_MS_CYC < 2) begin : g_chk
    $error("hws_sequencer: HALF_MS_CYC must be at least 2");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [hws_pkg::NUM_STEPS-1:0][SW-1:0] tab_setup;
    logic [hws_pkg::NUM_STEPS-1:0][DW-1:0] tab_dur;
    logic [IW-1:0]    last;
    logic [SW-1:0]    saved;
    logic [SW-1:0]    applied;
    hws_pkg::hws_fsm_t fsm;
    logic             active;
    logic             run;
    logic [IW-1:0]    idx;
    logic [CW-1:0]    cnt;
    logic [CW-1:0]    tgt;
    logic [10:0]      esc_cnt;
    logic             ext_prev;
    logic             marker;
    logic             out_en;
    logic             wave_load;
    logic             phase_keep;
    logic [SW-1:0]    wave_setup;
    logic             disp_update;
    logic [IW-1:0]    disp_idx;
    logic             nv_busy;
    logic [IW-1:0]    nv_ptr;
    logic             nv_valid;
    logic [IW-1:0]    nv_idx;
    logic [SW-1:0]    nv_setup;
    logic [DW-1:0]    nv_dur;
  } hws_state_t;

  hws_state_t st;
  hws_state_t next_st;
  logic       tick;

  hws_tick #(
    .DIV (HALF_MS_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (tick)
  );

  // ---------------------------------------------------------------
  // settle time of a change, in half-ms ticks
  // ---------------------------------------------------------------
  // the slowest applicable change wins; an attenuator switch keeps the
  // output off for its whole hold and the marker rises one tick after
  function automatic logic [CW-1:0] settle_ht(input logic [SW-1:0] old_s, input logic [SW-1:0] new_s);
    logic [CW-1:0] t;
    t = hws_pkg::SET_FREQ_HT;
    if (old_s[hws_pkg::SHAPE_LSB +: hws_pkg::SHAPE_W] != new_s[hws_pkg::SHAPE_LSB +: hws_pkg::SHAPE_W]) begin
      t = hws_pkg::SET_SHAPE_HT;
    end
    if (old_s[hws_pkg::FILT_BIT] != new_s[hws_pkg::FILT_BIT]) begin
      t = hws_pkg::SET_SHAPE_HT + hws_pkg::SET_FILT_HT;
    end
    if ((old_s[hws_pkg::AMP_LSB +: hws_pkg::AMP_W] != new_s[hws_pkg::AMP_LSB +: hws_pkg::AMP_W]) ||
        (old_s[hws_pkg::OFS_LSB +: hws_pkg::OFS_W] != new_s[hws_pkg::OFS_LSB +: hws_pkg::OFS_W])) begin
      if (t < hws_pkg::SET_AMP_HT) begin
        t = hws_pkg::SET_AMP_HT;
      end
    end
    if (old_s[hws_pkg::ATT_LSB +: hws_pkg::ATT_W] != new_s[hws_pkg::ATT_LSB +: hws_pkg::ATT_W]) begin
      t = hws_pkg::SET_ATT_HT + CW'(1);
    end
    return t;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic          ext_rise;
    logic          step_evt;
    logic          forced;
    logic          enter;
    logic [IW-1:0] eidx;
    logic [IW-1:0] nidx;
    logic [DW-1:0] cur_dur;
    logic [CW-1:0] cnt_inc;
    logic [SW-1:0] new_s;
    logic [SW-1:0] diff;
    ext_rise = 1'b0;
    step_evt = 1'b0;
    forced   = 1'b0;
    enter    = 1'b0;
    eidx     = '0;
    nidx     = '0;
    cur_dur  = '0;
    cnt_inc  = '0;
    new_s    = '0;
    diff     = '0;

    next_st             = st;
    next_st.wave_load   = 1'b0;
    next_st.disp_update = 1'b0;
    next_st.nv_valid    = 1'b0;

    ext_rise         = external_step_input & ~st.ext_prev;
    next_st.ext_prev = external_step_input;
    step_evt         = manual_step_key | remote_step;
    nidx             = (st.idx == st.last) ? '0 : st.idx + IW'(1);
    cur_dur          = st.tab_dur[st.idx];
    cnt_inc          = st.cnt + CW'(1);

    // table edits only while stopped and not saving
    if (!st.run && !st.nv_busy) begin
      if (edit_we) begin
        next_st.tab_setup[edit_idx] = edit_setup;
        // durations above the longest internal time are held at it
        next_st.tab_dur[edit_idx] = (edit_dur > hws_pkg::DUR_MAX_MS) ? hws_pkg::DUR_MAX_MS : edit_dur;
      end
      if (last_we) begin
        next_st.last = last_data;
      end
    end

    // escape held: counted on the slow tick so it works even when steps are too short
    if (st.active && escape_key) begin
      if (tick && st.esc_cnt != hws_pkg::ESC_HOLD_HT) begin
        next_st.esc_cnt = st.esc_cnt + 11'd1;
      end
    end else begin
      next_st.esc_cnt = '0;
    end
    forced = st.active && (st.esc_cnt == hws_pkg::ESC_HOLD_HT);

    if (hop_enter && !st.active) begin
      next_st.saved  = main_setup;
      next_st.active = 1'b1;
    end else if (st.active && (hop_exit || forced)) begin
      next_st.active     = 1'b0;
      next_st.run        = 1'b0;
      next_st.fsm        = hws_pkg::HWS_STOP;
      next_st.marker     = 1'b1;
      next_st.out_en     = 1'b1;
      next_st.esc_cnt    = '0;
      next_st.wave_setup = st.saved;
      next_st.applied    = st.saved;
      next_st.wave_load  = 1'b1;
      next_st.phase_keep = 1'b0;
    end else if (st.active && run_toggle) begin
      if (st.run) begin
        next_st.run    = 1'b0;
        next_st.fsm    = hws_pkg::HWS_STOP;
        next_st.marker = 1'b1;
        next_st.out_en = 1'b1;
      end else begin
        enter = 1'b1;
        eidx  = '0;
      end
    end else if (st.run) begin
      unique case (st.fsm)
        hws_pkg::HWS_TRIG: begin
          if (tick) begin
            next_st.cnt = cnt_inc;
            if (cnt_inc == hws_pkg::TRIG_DLY_HT) begin
              enter = 1'b1;
              eidx  = nidx;
            end
          end
        end
        hws_pkg::HWS_SETTLE: begin
          if (tick) begin
            next_st.cnt = cnt_inc;
            if (cnt_inc == hws_pkg::SET_ATT_HT) begin
              next_st.out_en = 1'b1;
            end
            if (cnt_inc == st.tgt) begin
              next_st.marker = 1'b1;
              next_st.out_en = 1'b1;
              next_st.fsm    = hws_pkg::HWS_DWELL;
              next_st.cnt    = '0;
            end
          end
        end
        hws_pkg::HWS_DWELL: begin
          if (cur_dur == hws_pkg::DUR_MANUAL) begin
            if (step_evt) begin
              enter = 1'b1;
              eidx  = nidx;
            end
          end else if (cur_dur == hws_pkg::DUR_EXTERNAL) begin
            if (ext_rise) begin
              next_st.fsm = hws_pkg::HWS_TRIG;
              next_st.cnt = '0;
            end
          end else if (tick) begin
            next_st.cnt = cnt_inc;
            if (cnt_inc == {1'b0, cur_dur} + {1'b0, cur_dur}) begin
              enter = 1'b1;
              eidx  = nidx;
            end
          end
        end
        default: begin
          next_st.fsm = hws_pkg::HWS_STOP;
          next_st.run = 1'b0;
        end
      endcase
    end

    // step entry: load the set-up, drop the marker, start settle timing
    if (enter) begin
      new_s              = st.tab_setup[eidx];
      diff               = new_s ^ st.applied;
      next_st.run        = 1'b1;
      next_st.idx        = eidx;
      next_st.wave_setup = new_s;
      next_st.applied    = new_s;
      next_st.wave_load  = 1'b1;
      next_st.phase_keep = (diff[hws_pkg::FREQ_LSB +: hws_pkg::FREQ_W] != '0) &&
                           (diff[hws_pkg::FREQ_LSB-1:0] == '0);
      next_st.marker     = 1'b0;
      next_st.out_en     = (diff[hws_pkg::ATT_LSB +: hws_pkg::ATT_W] == '0);
      next_st.tgt        = settle_ht(st.applied, new_s);
      next_st.cnt        = '0;
      next_st.fsm        = hws_pkg::HWS_SETTLE;
      if ((st.tab_dur[eidx] == hws_pkg::DUR_MANUAL) || (st.tab_dur[eidx] > hws_pkg::DISP_MIN_MS)) begin
        next_st.disp_update = 1'b1;
        next_st.disp_idx    = eidx;
      end
    end

    // power-down: stream the whole table and last index to the save store
    if (pwr_down && !st.nv_busy) begin
      next_st.nv_busy = 1'b1;
      next_st.nv_ptr  = '0;
    end
    if (st.nv_busy) begin
      next_st.nv_valid = 1'b1;
      next_st.nv_idx   = st.nv_ptr;
      next_st.nv_setup = st.tab_setup[st.nv_ptr];
      next_st.nv_dur   = st.tab_dur[st.nv_ptr];
      next_st.nv_ptr   = st.nv_ptr + IW'(1);
      if (st.nv_ptr == IW'(hws_pkg::NUM_STEPS - 1)) begin
        next_st.nv_busy = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // the table is only reset here; a defaults reload elsewhere never reaches it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.tab_setup <= {hws_pkg::NUM_STEPS{hws_pkg::SETUP_DEFAULT}};
      st.tab_dur   <= {hws_pkg::NUM_STEPS{hws_pkg::DUR_DEFAULT_MS}};
      st.last      <= hws_pkg::LAST_DEFAULT;
      st.fsm       <= hws_pkg::HWS_STOP;
      st.marker    <= 1'b1;
      st.out_en    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wave_setup         = st.wave_setup;
  assign wave_load          = st.wave_load;
  assign phase_keep         = st.phase_keep;
  assign output_enable      = st.out_en;
  assign step_marker_output = st.marker;
  assign hop_active         = st.active;
  assign hop_running        = st.run;
  assign step_idx           = st.idx;
  assign disp_update        = st.disp_update;
  assign disp_idx           = st.disp_idx;
  assign edit_blocked       = st.run;
  assign nv_valid           = st.nv_valid;
  assign nv_idx             = st.nv_idx;
  assign nv_setup           = st.nv_setup;
  assign nv_dur             = st.nv_dur;
  assign nv_last            = st.last;
endmodule

`default_nettype wire

// ---- hws_tick.sv ----
// holds the shared constants package of the waveform hop sequencer and its half-millisecond tick divider
// assumes one free-running core clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

package hws_pkg;
  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned HALF_MS_NS     = 500_000;
  localparam int unsigned HALF_MS_CYC    = HALF_MS_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // step table
  // ---------------------------------------------------------------
  localparam int unsigned NUM_STEPS      = 16;
  localparam int unsigned IDX_W          = 4;
  localparam int unsigned DUR_W          = 16;
  localparam int unsigned CNT_W          = 17;
  localparam logic [15:0] DUR_MANUAL     = 16'h0000;
  localparam logic [15:0] DUR_EXTERNAL   = 16'h0001;
  localparam logic [15:0] DUR_MIN_MS     = 16'h0002;
  localparam logic [15:0] DUR_MAX_MS     = 16'hFDE8;
  localparam logic [15:0] DUR_DEFAULT_MS = 16'h03E8;
  localparam logic [15:0] DISP_MIN_MS    = 16'h01F4;
  localparam logic [3:0]  LAST_DEFAULT   = 4'h1;
  // ---------------------------------------------------------------
  // set-up word layout: freq | shape | filter | atten | ampl | offset
  // ---------------------------------------------------------------
  localparam int unsigned OFS_LSB        = 0;
  localparam int unsigned OFS_W          = 12;
  localparam int unsigned AMP_LSB        = 12;
  localparam int unsigned AMP_W          = 12;
  localparam int unsigned ATT_LSB        = 24;
  localparam int unsigned ATT_W          = 2;
  localparam int unsigned FILT_BIT       = 26;
  localparam int unsigned SHAPE_LSB      = 27;
  localparam int unsigned SHAPE_W        = 3;
  localparam int unsigned FREQ_LSB       = 30;
  localparam int unsigned FREQ_W         = 32;
  localparam int unsigned SETUP_W        = 62;
  localparam logic [61:0] SETUP_DEFAULT  = 62'h0000_0000_0000_0000;
  // ---------------------------------------------------------------
  // settle and hold times, in half-millisecond ticks
  // ---------------------------------------------------------------
  localparam logic [16:0] TRIG_DLY_HT    = 17'h0_0002;
  localparam logic [16:0] SET_FREQ_HT    = 17'h0_0001;
  localparam logic [16:0] SET_SHAPE_HT   = 17'h0_0006;
  localparam logic [16:0] SET_FILT_HT    = 17'h0_000A;
  localparam logic [16:0] SET_AMP_HT     = 17'h0_0014;
  localparam logic [16:0] SET_ATT_HT     = 17'h0_005A;
  localparam logic [10:0] ESC_HOLD_HT    = 11'h7D0;

  typedef enum logic [3:0] {
    HWS_STOP   = 4'b0001,
    HWS_TRIG   = 4'b0010,
    HWS_SETTLE = 4'b0100,
    HWS_DWELL  = 4'b1000
  } hws_fsm_t;
endpackage

module hws_tick #(
  parameter int unsigned DIV = hws_pkg::HALF_MS_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // one-cycle enable every DIV clocks
  output var  logic tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  if (DIV < 2) begin : g_chk
    $error("hws_tick: DIV must be at least 2");
  end

  logic [CW-1:0] cnt;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- hws_sequencer_asserts.sv ----
// port checker for the hop sequencer, bound onto every hws_sequencer
// assumes all ports are sampled on core_clk and rstn is an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module hws_seq_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // controls
  input wire logic       hop_enter,
  input wire logic       hop_exit,
  input wire logic       escape_key,
  input wire logic       run_toggle,
  input wire logic       pwr_down,
  // observed outputs
  input wire logic       wave_load,
  input wire logic       output_enable,
  input wire logic       step_marker_output,
  input wire logic       hop_active,
  input wire logic       hop_running,
  input wire logic       disp_update,
  input wire logic       edit_blocked,
  input wire logic       nv_valid,
  input wire logic [3:0] step_idx,
  input wire logic [3:0] nv_idx
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_enter_takes: assert property (hop_enter && !hop_active |=> hop_active)
    else $error("enter ignored");
  a_run_start: assert property (run_toggle && hop_active && !hop_running && !hop_exit && !escape_key
    |=> hop_running && wave_load && !step_marker_output && step_idx == 4'h0) else $error("bad start");
  a_exit_restore: assert property (hop_exit && hop_active
    |=> !hop_active && !hop_running && step_marker_output && output_enable && wave_load) else $error("bad exit");
  a_edit_lock: assert property (edit_blocked == hop_running && (!hop_running || hop_active))
    else $error("edit lock mismatch");
  a_stop_marker: assert property (!hop_running |-> step_marker_output)
    else $error("marker low while stopped");
  a_entry_marker: assert property (wave_load && hop_running |-> !step_marker_output)
    else $error("marker high at entry");
  a_idle_oe: assert property (!hop_active |-> output_enable)
    else $error("output off while idle");
  a_disp_run: assert property (disp_update |-> hop_running)
    else $error("display update while stopped");
  a_step_order: assert property (hop_running && $changed(step_idx)
    |-> step_idx == 4'h0 || step_idx == $past(step_idx) + 4'h1) else $error("step skipped");
  a_save_start: assert property (pwr_down && !nv_valid && !hop_running |-> ##[1:3] nv_valid)
    else $error("save not started");
  a_save_first: assert property ($rose(nv_valid) |-> nv_idx == 4'h0)
    else $error("save not from step zero");
  a_save_seq: assert property (nv_valid && nv_idx != 4'hf |=> nv_valid && nv_idx == $past(nv_idx) + 4'h1)
    else $error("save stream broken");
endmodule
bind hws_sequencer hws_seq_chk u_chk (.*);
`default_nettype wire

// ---- hws_panel.sv ----
// panel, remote and trigger source model driving the sequencer's event inputs
// assumes the bench asks for one event at a time through cmd and cmd_go
`timescale 1ns/1ps
`default_nettype none
module hws_panel (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // request: 0 enter, 1 exit, 2 run/stop, 3 key, 4 remote, 5 trigger
  input  wire logic       cmd_go,
  input  wire logic [2:0] cmd,
  // event lines
  output var  logic       hop_enter,
  output var  logic       hop_exit,
  output var  logic       run_toggle,
  output var  logic       manual_step_key,
  output var  logic       remote_step,
  output var  logic       external_step_input
);
  logic [1:0] trig_hold;
  // single-cycle pulses and a three-cycle trigger high, so one request gives exactly one event
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {hop_enter, hop_exit, run_toggle, manual_step_key, remote_step} <= 5'h00;
      trig_hold <= 2'h0;
    end else begin
      hop_enter       <= cmd_go && cmd == 3'h0;
      hop_exit        <= cmd_go && cmd == 3'h1;
      run_toggle      <= cmd_go && cmd == 3'h2;
      manual_step_key <= cmd_go && cmd == 3'h3;
      remote_step     <= cmd_go && cmd == 3'h4;
      trig_hold       <= (cmd_go && cmd == 3'h5) ? 2'h3 : trig_hold - {1'b0, trig_hold != 2'h0};
    end
  end
  // trigger idles low, one rising edge per requested step
  assign external_step_input = trig_hold != 2'h0;
endmodule
`default_nettype wire

// ---- tb_hws_sequencer.sv ----
// self-checking bench for hws_sequencer with the panel and trigger model
// assumes hws_pkg, the design, the panel model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_hws_sequencer;
  localparam logic [61:0] F1 = 62'h0000_4000_0000;
  localparam logic [61:0] F2 = 62'h0000_8000_0000;
  localparam logic [61:0] SH = 62'h0000_0800_0000;
  localparam logic [61:0] AT = 62'h0000_0100_0000;
  logic        core_clk, rstn, escape_key, edit_we, last_we, pwr_down, cmd_go;
  logic        wave_load, phase_keep, output_enable, step_marker_output, hop_active, hop_running;
  logic        disp_update, edit_blocked, nv_valid;
  wire logic   hop_enter, hop_exit, run_toggle, manual_step_key, remote_step, external_step_input;
  logic [2:0]  cmd;
  logic [3:0]  edit_idx, last_data, step_idx, disp_idx, nv_idx, nv_last, tab_last;
  logic [15:0] edit_dur, nv_dur;
  logic [61:0] edit_setup, main_setup, wave_setup, nv_setup;
  logic [61:0] tab_s [16];
  logic [15:0] tab_d [16];
  int          miscompares, total_checks, disp_cnt, n;
  // a half-ms tick every 4 cycles keeps millisecond counts short
  hws_sequencer #(.HALF_MS_CYC(4)) uut (.*);
  hws_panel u_panel (.*);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (disp_update === 1'b1) disp_cnt++;
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick1();
    @(posedge core_clk);
    #1;
  endtask
  task automatic send(input logic [2:0] c);
    cmd = c;
    cmd_go = 1'b1;
    tick1();
    cmd_go = 1'b0;
    tick1();
  endtask
  task automatic wait_mark(output int cnt);
    for (cnt = 0; step_marker_output !== 1'b1 && cnt < 500; cnt++) tick1();
    chk("mark_wait", cnt < 500, 1'b1);
  endtask
  task automatic wait_load(output int cnt);
    for (cnt = 0; wave_load !== 1'b1 && cnt < 500; cnt++) tick1();
    chk("load_wait", cnt < 500, 1'b1);
  endtask
  task automatic prog(input logic [3:0] i, input logic [61:0] s, input logic [15:0] d);
    {edit_idx, edit_setup, edit_dur} = {i, s, d};
    edit_we = 1'b1;
    tick1();
    edit_we = 1'b0;
    if (hop_running !== 1'b1) begin
      tab_s[i] = s;
      tab_d[i] = (d > hws_pkg::DUR_MAX_MS) ? hws_pkg::DUR_MAX_MS : d;
    end
    tick1();
  endtask
  task automatic set_last(input logic [3:0] l);
    last_data = l;
    last_we = 1'b1;
    tick1();
    last_we = 1'b0;
    tab_last = l;
    tick1();
  endtask
  task automatic t_save();
    pwr_down = 1'b1;
    tick1();
    pwr_down = 1'b0;
    for (n = 0; nv_valid !== 1'b1 && n < 4; n++) tick1();
    for (int i = 0; i < 16; i++) begin
      chk("nv_idx", nv_idx, i[3:0]);
      chk("nv_setup", nv_setup, tab_s[i]);
      chk("nv_dur", nv_dur, tab_d[i]);
      chk("nv_last", nv_last, tab_last);
      tick1();
    end
  endtask
  task automatic t_internal();
    prog(4'h0, F1, 16'h0002);
    prog(4'h1, F2, 16'h0002);
    set_last(4'h1);
    send(3'h0);
    chk("active", hop_active, 1'b1);
    send(3'h2);
    disp_cnt = 0;
    chk("load", wave_load, 1'b1);
    chk("idx0", step_idx, 4'h0);
    chk("setup0", wave_setup, F1);
    wait_mark(n);
    wait_load(n);
    chk("dwell", n >= 15 && n <= 17, 1'b1);
    chk("idx1", step_idx, 4'h1);
    wait_mark(n);
    chk("freq_settle", n >= 1 && n <= 5, 1'b1);
    chk("phase", phase_keep, 1'b1);
    prog(4'h1, SH, 16'h0009);
    wait_load(n);
    chk("wrap", step_idx, 4'h0);
    wait_mark(n);
    wait_load(n);
    chk("refused", wave_setup, F2);
    chk("blocked", edit_blocked, 1'b1);
    chk("no_disp", disp_cnt, 0);
    send(3'h2);
    chk("stopped", {hop_running, step_marker_output}, 2'h1);
  endtask
  task automatic t_shape_atten();
    prog(4'h0, F1, 16'h000A);
    prog(4'h1, F1 | SH, 16'h000A);
    prog(4'h2, F1 | SH | AT, 16'h0032);
    set_last(4'h2);
    send(3'h2);
    wait_mark(n);
    wait_load(n);
    wait_mark(n);
    chk("shape_settle", n >= 20 && n <= 25, 1'b1);
    chk("no_phase", phase_keep, 1'b0);
    wait_load(n);
    chk("oe_off", output_enable, 1'b0);
    for (n = 0; output_enable !== 1'b1 && n < 500; n++) tick1();
    chk("oe_span", n >= 356 && n <= 361, 1'b1);
    chk("mark_held", step_marker_output, 1'b0);
    wait_mark(n);
    chk("mark_late", n >= 1 && n <= 5, 1'b1);
    send(3'h1);
    chk("restore", wave_setup, main_setup);
    chk("exited", {hop_active, output_enable}, 2'h1);
  endtask
  task automatic t_manual();
    prog(4'h0, F1, 16'h0000);
    prog(4'h1, F2, 16'h0000);
    set_last(4'h1);
    send(3'h0);
    disp_cnt = 0;
    send(3'h2);
    wait_mark(n);
    chk("disp", disp_cnt, 1);
    chk("ampl_settle", n >= 76 && n <= 80, 1'b1);
    send(3'h3);
    wait_load(n);
    chk("key_step", {n <= 1, step_idx}, 5'h11);
    chk("disp_idx", disp_idx, 4'h1);
    wait_mark(n);
    send(3'h4);
    wait_load(n);
    chk("remote_step", {n <= 1, step_idx}, 5'h10);
    send(3'h1);
  endtask
  task automatic t_ext_escape();
    prog(4'h0, F1, 16'h0001);
    prog(4'h1, F2, 16'h0001);
    prog(4'h3, SH, 16'hFFFF);
    send(3'h0);
    send(3'h2);
    wait_mark(n);
    send(3'h5);
    wait_load(n);
    chk("trig_delay", n >= 3 && n <= 10, 1'b1);
    chk("trig_step", step_idx, 4'h1);
    escape_key = 1'b1;
    for (n = 0; hop_active === 1'b1 && n < 8200; n++) tick1();
    escape_key = 1'b0;
    chk("escape_hold", n >= 7990 && n <= 8010, 1'b1);
    chk("escape_stop", {hop_running, step_marker_output}, 2'h1);
  endtask
  initial begin
    {rstn, escape_key, edit_we, last_we, pwr_down, cmd_go} = 6'h00;
    {cmd, edit_idx, last_data, edit_dur, edit_setup} = '0;
    main_setup = 62'h0000_0000_0123;
    {miscompares, total_checks, disp_cnt} = '0;
    tab_last = 4'h1;
    foreach (tab_s[i]) {tab_s[i], tab_d[i]} = {62'h0, 16'h03E8};
    repeat (6) @(posedge core_clk);
    #1 rstn = 1'b1;
    chk("reset_out", {step_marker_output, output_enable, hop_active, wave_load}, 4'hC);
    t_save();
    t_internal();
    t_shape_atten();
    t_manual();
    t_ext_escape();
    t_save();
    complete_run();
  end
  initial begin
    #750_000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
